/* acp_regs.vh */
// Character codes, token kinds, radix and reset values of the parser
`ifndef ACP_REGS_VH
`define ACP_REGS_VH
// Characters
`define ACP_CH_LF     8'h0a
`define ACP_CH_SP     8'h20
`define ACP_CH_DQ     8'h22
`define ACP_CH_HASH   8'h23
`define ACP_CH_SQ     8'h27
`define ACP_CH_STAR   8'h2a
`define ACP_CH_PLUS   8'h2b
`define ACP_CH_COMMA  8'h2c
`define ACP_CH_MINUS  8'h2d
`define ACP_CH_DOT    8'h2e
`define ACP_CH_COLON  8'h3a
`define ACP_CH_SEMI   8'h3b
`define ACP_CH_QMARK  8'h3f
`define ACP_CH_USCORE 8'h5f
// Token kinds
`define ACP_TK_HDR    4'h0
`define ACP_TK_ROOT   4'h1
`define ACP_TK_COMMON 4'h2
`define ACP_TK_NUM    4'h3
`define ACP_TK_UNIT   4'h4
`define ACP_TK_STR    4'h5
`define ACP_TK_KEY    4'h6
`define ACP_TK_PSEP   4'h7
`define ACP_TK_CMDEND 4'h8
`define ACP_TK_EXEC   4'h9
`define ACP_TK_ERR    4'ha
`define ACP_TK_BLOCK  4'hb
// Radix values
`define ACP_RAD_BIN   5'h02
`define ACP_RAD_OCT   5'h08
`define ACP_RAD_DEC   5'h0a
`define ACP_RAD_HEX   5'h10
// Reset values
`define ACP_LONG_RST  1'b1
`define ACP_VAL_RST   32'h0
`endif

/* acp_buf2.v */
// Two-entry token buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module acp_buf2 #(
    parameter W  = 44,
    parameter AW = 1
) (
    input  wire         clk,
    input  wire         rst,
    input  wire         flush,
    input  wire         in_valid,
    output wire         in_ready,
    input  wire [W-1:0] in_data,
    output wire         out_valid,
    input  wire         out_ready,
    output wire [W-1:0] out_data
);
    localparam [AW:0] DEPTH = {{AW{1'b0}}, 1'b1} << AW;

    reg  [W-1:0]  slot_r [0:DEPTH-1];
    reg  [AW-1:0] wp_r;
    reg  [AW-1:0] rp_r;
    reg  [AW:0]   cnt_r;
    wire          push;
    wire          pop;

    // Full and empty from the fill count
    assign in_ready  = (cnt_r != DEPTH);
    assign out_valid = (cnt_r != {(AW+1){1'b0}});
    assign out_data  = slot_r[rp_r];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // Storage needs no reset; the count decides what is valid
    always @(posedge clk)
    begin
        if (push)
            slot_r[wp_r] <= in_data;
    end

    // Pointers and count; flush drops whatever is held
    always @(posedge clk)
    begin
        if (rst || flush)
        begin
            wp_r  <= {AW{1'b0}};
            rp_r  <= {AW{1'b0}};
            cnt_r <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
                wp_r <= wp_r + 1'b1;
            if (pop)
                rp_r <= rp_r + 1'b1;
            cnt_r <= cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
endmodule // acp_buf2
`default_nettype wire

/* acp_parser.v */
// ASCII program-message parser: bytes to command tokens
// Behaviour
// - Header ends at white space
// - Commas split parameters; spaces allowed
// - Exponent or unit suffix, never both
// - #B #Q #H select radix, else decimal
// - Integers drop fraction; reals keep it
// - ASCII digits converted to binary
// - Strings in single or double quotes
// - String characters kept exactly, spaces too
// - Keywords matched regardless of case
// - Replies upper case, long/short per setting
// - Execute only on line feed
// - End-of-string/text acts as terminator
// - Semicolon then colon returns to root
// - Any mix of command kinds per line
// - Interface clear resets parser, drops partial
// - Block data only for five instructions
// - White space is spaces only
// - No separator after the asterisk
// - Command over unread response: flush, error
`timescale 1ns/1ps
`default_nettype none
`include "acp_regs.vh"
module acp_parser #(
    parameter VW = 32
) (
    input  wire          REF_CLK,
    input  wire          SRST,
    input  wire          IFC,
    input  wire          RX_VALID,
    input  wire [7:0]    RX_DATA,
    input  wire          RX_EOS,
    input  wire          RX_EOT,
    output wire          RX_READY,
    input  wire          PARAM_INT,
    input  wire          BLOCK_OK,
    input  wire          RSP_PENDING,
    output wire          RSP_FLUSH,
    output wire          ERR_UNREAD,
    output wire          TOK_VALID,
    input  wire          TOK_READY,
    output wire [3:0]    TOK_KIND,
    output wire [VW-1:0] TOK_VALUE,
    output wire [7:0]    TOK_EXP,
    input  wire          LONG_SET_VALID,
    input  wire          LONG_SET_VAL,
    output wire          LONG_FORM,
    input  wire          RSP_KW_VALID,
    input  wire [7:0]    RSP_KW_DATA,
    output wire          RSP_KW_READY,
    output wire          TX_VALID,
    output wire [7:0]    TX_DATA,
    input  wire          TX_READY
);
    localparam [3:0] S_START = 4'h0, S_COMMON = 4'h1, S_HDR = 4'h2, S_WS = 4'h3;
    localparam [3:0] S_NUM = 4'h4, S_FRAC = 4'h5, S_ESGN = 4'h6, S_EXP = 4'h7;
    localparam [3:0] S_RADIX = 4'h8, S_RDIG = 4'h9, S_POST = 4'ha, S_UNIT = 4'hb;
    localparam [3:0] S_STR = 4'hc, S_KEY = 4'hd, S_BLOCK = 4'he, S_SKIP = 4'hf;

    reg  [3:0]    state_r, state_nxt;
    reg  [VW-1:0] val_r, val_nxt;
    reg  [7:0]    frac_r, frac_nxt;
    reg  [7:0]    eval_r, eval_nxt;
    reg           eneg_r, eneg_nxt;
    reg           neg_r, neg_nxt;
    reg           hasexp_r, hasexp_nxt;
    reg  [4:0]    rad_r, rad_nxt;
    reg  [7:0]    delim_r, delim_nxt;
    reg           msg_start_r;
    reg           flush_r;
    reg           long_r;
    reg           tx_valid_r;
    reg  [7:0]    tx_data_r;
    reg           hold, emit, err, num_done, after;
    reg  [3:0]    kind;
    reg  [VW-1:0] tval;
    wire          buf_ready;
    wire          fire;
    wire          end_ind;
    wire [7:0]    c;
    wire [4:0]    d;
    wire [7:0]    exp_out;
    wire          kw_take;

    function is_dec;
        input [7:0] ch;
        is_dec = (ch >= 8'h30) && (ch <= 8'h39);
    endfunction

    function is_lower;
        input [7:0] ch;
        is_lower = (ch >= 8'h61) && (ch <= 8'h7a);
    endfunction

    function is_alpha;
        input [7:0] ch;
        is_alpha = is_lower(ch) || ((ch >= 8'h41) && (ch <= 8'h5a));
    endfunction

    function [7:0] upcase;
        input [7:0] ch;
        upcase = is_lower(ch) ? (ch & 8'hdf) : ch;
    endfunction

    // Digit weight, 5'h1f for no digit
    function [4:0] dig_val;
        input [7:0] ch;
        reg   [7:0] u;
        begin
            u = upcase(ch);
            if (is_dec(ch))
                dig_val = ch[4:0] - 5'h10;
            else if ((u >= 8'h41) && (u <= 8'h46))
                dig_val = u[4:0] + 5'h09;
            else
                dig_val = 5'h1f;
        end
    endfunction

    function [VW-1:0] mac;
        input [VW-1:0] v;
        input [4:0]    r;
        input [4:0]    dg;
        mac = v * {{(VW-5){1'b0}}, r} + {{(VW-5){1'b0}}, dg};
    endfunction

    // End indications act as a line feed
    assign end_ind  = RX_EOS | RX_EOT;
    assign c        = end_ind ? `ACP_CH_LF : RX_DATA;
    assign d        = dig_val(c);
    assign fire     = RX_VALID & buf_ready;
    assign RX_READY = buf_ready;
    assign exp_out  = frac_r + (eneg_r ? (8'h00 - eval_r) : eval_r);

    // Next-state decode; at most one token per byte
    always @*
    begin
        state_nxt  = state_r;
        val_nxt    = val_r;
        frac_nxt   = frac_r;
        eval_nxt   = eval_r;
        eneg_nxt   = eneg_r;
        neg_nxt    = neg_r;
        hasexp_nxt = hasexp_r;
        rad_nxt    = rad_r;
        delim_nxt  = delim_r;
        hold       = 1'b0;
        emit       = 1'b0;
        err        = 1'b0;
        num_done   = 1'b0;
        after      = 1'b0;
        kind       = `ACP_TK_HDR;
        tval       = {{(VW-8){1'b0}}, upcase(c)};
        case (state_r)
            S_START:
                if (c == `ACP_CH_COLON)
                begin
                    emit      = 1'b1;
                    kind      = `ACP_TK_ROOT;
                    state_nxt = S_HDR;
                end
                else if (c == `ACP_CH_STAR)
                begin
                    emit      = 1'b1;
                    kind      = `ACP_TK_COMMON;
                    state_nxt = S_COMMON;
                end
                else if (is_alpha(c))
                begin
                    emit      = 1'b1;
                    state_nxt = S_HDR;
                end
                else if (c == `ACP_CH_LF)
                begin
                    emit = 1'b1;
                    kind = `ACP_TK_EXEC;
                end
                else if (c != `ACP_CH_SP)
                    err = 1'b1;
            S_COMMON:
                if (is_alpha(c))
                begin
                    emit      = 1'b1;
                    state_nxt = S_HDR;
                end
                else
                    err = 1'b1;
            S_HDR:
                if (is_alpha(c) || is_dec(c) || c == `ACP_CH_COLON || c == `ACP_CH_QMARK || c == `ACP_CH_USCORE)
                    emit = 1'b1;
                else if (c == `ACP_CH_SP)
                    state_nxt = S_WS;
                else
                    after = 1'b1;
            S_WS:
            begin
                // Every parameter starts as a fresh decimal number
                val_nxt    = is_dec(c) ? {{(VW-5){1'b0}}, d} : `ACP_VAL_RST;
                neg_nxt    = (c == `ACP_CH_MINUS);
                rad_nxt    = `ACP_RAD_DEC;
                frac_nxt   = 8'h00;
                eval_nxt   = 8'h00;
                eneg_nxt   = 1'b0;
                hasexp_nxt = 1'b0;
                if (c == `ACP_CH_SQ || c == `ACP_CH_DQ)
                begin
                    delim_nxt = c;
                    state_nxt = S_STR;
                end
                else if (is_dec(c) || c == `ACP_CH_PLUS || c == `ACP_CH_MINUS || c == `ACP_CH_DOT)
                    state_nxt = (c == `ACP_CH_DOT) ? S_FRAC : S_NUM;
                else if (c == `ACP_CH_HASH)
                    state_nxt = S_RADIX;
                else if (is_alpha(c))
                begin
                    emit      = 1'b1;
                    kind      = `ACP_TK_KEY;
                    state_nxt = S_KEY;
                end
                else if (c == `ACP_CH_LF)
                    after = 1'b1;
                else if (c != `ACP_CH_SP)
                    err = 1'b1;
            end
            S_NUM:
                if (is_dec(c))
                    val_nxt = mac(val_r, rad_r, d);
                else if (c == `ACP_CH_DOT)
                    state_nxt = S_FRAC;
                else if (upcase(c) == 8'h45)
                    state_nxt = S_ESGN;
                else
                    num_done = 1'b1;
            S_FRAC:
                if (is_dec(c))
                begin
                    // Integer parameters keep only the whole part
                    if (!PARAM_INT)
                    begin
                        val_nxt  = mac(val_r, rad_r, d);
                        frac_nxt = frac_r - 8'h01;
                    end
                end
                else if (upcase(c) == 8'h45)
                    state_nxt = S_ESGN;
                else
                    num_done = 1'b1;
            S_ESGN:
                if (is_dec(c) || c == `ACP_CH_PLUS || c == `ACP_CH_MINUS)
                begin
                    eneg_nxt   = (c == `ACP_CH_MINUS);
                    eval_nxt   = is_dec(c) ? {3'h0, d} : 8'h00;
                    hasexp_nxt = 1'b1;
                    state_nxt  = S_EXP;
                end
                else
                    err = 1'b1;
            S_EXP:
                if (is_dec(c))
                    eval_nxt = eval_r * 8'h0a + {3'h0, d};
                else if (is_alpha(c))
                    err = 1'b1;
                else
                    num_done = 1'b1;
            S_RADIX:
                if (upcase(c) == 8'h42 || upcase(c) == 8'h51 || upcase(c) == 8'h48)
                begin
                    rad_nxt   = (upcase(c) == 8'h42) ? `ACP_RAD_BIN :
                                (upcase(c) == 8'h51) ? `ACP_RAD_OCT : `ACP_RAD_HEX;
                    state_nxt = S_RDIG;
                end
                else if (is_dec(c) && BLOCK_OK)
                begin
                    emit      = 1'b1;
                    kind      = `ACP_TK_BLOCK;
                    tval      = {{(VW-8){1'b0}}, c};
                    state_nxt = S_BLOCK;
                end
                else
                    err = 1'b1;
            S_RDIG:
                if (d < rad_r)
                    val_nxt = mac(val_r, rad_r, d);
                else if (is_alpha(c) || c == `ACP_CH_DOT)
                    err = 1'b1;
                else
                    num_done = 1'b1;
            S_POST:
                // Letters after a plain decimal number are its unit
                if (is_alpha(c) && rad_r == `ACP_RAD_DEC && !hasexp_r)
                begin
                    emit      = 1'b1;
                    kind      = `ACP_TK_UNIT;
                    state_nxt = S_UNIT;
                end
                else
                    after = 1'b1;
            S_UNIT:
                if (is_alpha(c))
                begin
                    emit = 1'b1;
                    kind = `ACP_TK_UNIT;
                end
                else
                    after = 1'b1;
            S_STR:
                if (c == delim_r)
                    state_nxt = S_POST;
                else if (c == `ACP_CH_LF)
                begin
                    err  = 1'b1;
                    hold = 1'b1;
                end
                else
                begin
                    emit = 1'b1;
                    kind = `ACP_TK_STR;
                    tval = {{(VW-8){1'b0}}, c};
                end
            S_KEY:
                if (is_alpha(c) || is_dec(c) || c == `ACP_CH_USCORE)
                begin
                    emit = 1'b1;
                    kind = `ACP_TK_KEY;
                end
                else
                    after = 1'b1;
            S_BLOCK:
                if (c == `ACP_CH_LF)
                    after = 1'b1;
                else
                begin
                    emit = 1'b1;
                    kind = `ACP_TK_BLOCK;
                    tval = {{(VW-8){1'b0}}, c};
                end
            default:
                if (c == `ACP_CH_LF)
                begin
                    emit      = 1'b1;
                    kind      = `ACP_TK_EXEC;
                    state_nxt = S_START;
                end
        endcase
        // A finished number goes out now; its delimiter byte is consumed here, so the sender repeats it
        if (num_done)
        begin
            emit      = 1'b1;
            hold      = 1'b1;
            kind      = `ACP_TK_NUM;
            tval      = neg_r ? ({VW{1'b0}} - val_r) : val_r;
            state_nxt = S_POST;
        end
        // Separators after a header or a parameter
        if (after)
        begin
            if (c == `ACP_CH_SP)
                state_nxt = S_POST;
            else if (c == `ACP_CH_COMMA && state_r != S_HDR)
            begin
                emit      = 1'b1;
                kind      = `ACP_TK_PSEP;
                state_nxt = S_WS;
            end
            else if (c == `ACP_CH_SEMI)
            begin
                emit      = 1'b1;
                kind      = `ACP_TK_CMDEND;
                state_nxt = S_START;
            end
            else if (c == `ACP_CH_LF)
            begin
                emit      = 1'b1;
                kind      = `ACP_TK_EXEC;
                state_nxt = S_START;
            end
            else
                err = 1'b1;
        end
        // A syntax fault skips to the terminator
        if (err)
        begin
            emit      = 1'b1;
            kind      = `ACP_TK_ERR;
            tval      = {{(VW-8){1'b0}}, c};
            state_nxt = S_SKIP;
        end
    end

    // Parser state; interface clear resets only the parser
    always @(posedge REF_CLK)
    begin
        if (SRST || IFC)
        begin
            state_r     <= S_START;
            val_r       <= `ACP_VAL_RST;
            frac_r      <= 8'h00;
            eval_r      <= 8'h00;
            eneg_r      <= 1'b0;
            neg_r       <= 1'b0;
            hasexp_r    <= 1'b0;
            rad_r       <= `ACP_RAD_DEC;
            delim_r     <= `ACP_CH_DQ;
            msg_start_r <= 1'b1;
        end
        else if (fire)
        begin
            state_r  <= state_nxt;
            val_r    <= val_nxt;
            frac_r   <= frac_nxt;
            eval_r   <= eval_nxt;
            eneg_r   <= eneg_nxt;
            neg_r    <= neg_nxt;
            hasexp_r <= hasexp_nxt;
            rad_r    <= rad_nxt;
            delim_r  <= delim_nxt;
            if (emit && kind == `ACP_TK_EXEC)
                msg_start_r <= 1'b1;
            else if (!hold)
                msg_start_r <= 1'b0;
        end
    end

    // New message over an unread response; one pulse serves flush and error
    always @(posedge REF_CLK)
    begin
        if (SRST)
            flush_r <= 1'b0;
        else
            flush_r <= fire && msg_start_r && RSP_PENDING;
    end

    assign RSP_FLUSH  = flush_r;
    assign ERR_UNREAD = flush_r;

    // Tokens survive a stalled consumer; a clear drops them
    acp_buf2 #(
        .W  (VW + 12),
        .AW (1)
    ) u_tok_buf (
        .clk       (REF_CLK),
        .rst       (SRST),
        .flush     (IFC),
        .in_valid  (fire & emit),
        .in_ready  (buf_ready),
        .in_data   ({kind, exp_out, tval}),
        .out_valid (TOK_VALID),
        .out_ready (TOK_READY),
        .out_data  ({TOK_KIND, TOK_EXP, TOK_VALUE})
    );

    // Reply formatter; short form drops lower-case letters, keeps the rest
    assign kw_take      = RSP_KW_VALID & RSP_KW_READY;
    assign RSP_KW_READY = !tx_valid_r || TX_READY;
    always @(posedge REF_CLK)
    begin
        if (SRST)
        begin
            long_r     <= `ACP_LONG_RST;
            tx_valid_r <= 1'b0;
            tx_data_r  <= 8'h00;
        end
        else
        begin
            if (LONG_SET_VALID)
                long_r <= LONG_SET_VAL;
            if (kw_take)
            begin
                tx_valid_r <= long_r || !is_lower(RSP_KW_DATA);
                tx_data_r  <= upcase(RSP_KW_DATA);
            end
            else if (TX_READY)
                tx_valid_r <= 1'b0;
        end
    end

    assign LONG_FORM = long_r;
    assign TX_VALID  = tx_valid_r;
    assign TX_DATA   = tx_data_r;
endmodule // acp_parser
`default_nettype wire

/* acp_parser_assertions.sv */
// Concurrent checks on the parser's ports
`timescale 1ns/1ps
`default_nettype none
`include "acp_regs.vh"
module acp_parser_assertions #(
    parameter VW = 32
) (
    input wire logic          REF_CLK,
    input wire logic          SRST,
    input wire logic          IFC,
    input wire logic          RX_VALID,
    input wire logic          RX_READY,
    input wire logic          RSP_PENDING,
    input wire logic          RSP_FLUSH,
    input wire logic          ERR_UNREAD,
    input wire logic          TOK_VALID,
    input wire logic          TOK_READY,
    input wire logic [3:0]    TOK_KIND,
    input wire logic [VW-1:0] TOK_VALUE,
    input wire logic          LONG_SET_VALID,
    input wire logic          LONG_SET_VAL,
    input wire logic          LONG_FORM,
    input wire logic          TX_VALID,
    input wire logic [7:0]    TX_DATA,
    input wire logic          TX_READY
);
    // One clock domain
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (SRST);
    property p_flush_pair; (RSP_FLUSH || ERR_UNREAD) |-> RSP_FLUSH && ERR_UNREAD ##1 !RSP_FLUSH; endproperty
    a_flush_pair: assert property (p_flush_pair) else $error("flush pulse");
    property p_flush_cause; $rose(RSP_FLUSH) |-> $past(RSP_PENDING && RX_VALID && RX_READY); endproperty
    a_flush_cause: assert property (p_flush_cause) else $error("stray flush");
    property p_long_load; LONG_SET_VALID |=> LONG_FORM == $past(LONG_SET_VAL); endproperty
    a_long_load: assert property (p_long_load) else $error("setting not loaded");
    property p_long_keep; !LONG_SET_VALID |=> $stable(LONG_FORM); endproperty
    a_long_keep: assert property (p_long_keep) else $error("setting drifted");
    property p_tx_upper; TX_VALID |-> !(TX_DATA inside {[8'h61:8'h7a]}); endproperty
    a_tx_upper: assert property (p_tx_upper) else $error("lower-case reply");
    property p_tx_hold; TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA); endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("reply not held");
    property p_tok_hold; TOK_VALID && !TOK_READY && !IFC |=> TOK_VALID && $stable({TOK_KIND, TOK_VALUE}); endproperty
    a_tok_hold: assert property (p_tok_hold) else $error("token not held");
    property p_ifc_clear; IFC |=> !TOK_VALID && RX_READY; endproperty
    a_ifc_clear: assert property (p_ifc_clear) else $error("clear left tokens");
    property p_key_upper;
        TOK_VALID && TOK_KIND inside {`ACP_TK_HDR, `ACP_TK_KEY} |-> !(TOK_VALUE[7:0] inside {[8'h61:8'h7a]});
    endproperty
    a_key_upper: assert property (p_key_upper) else $error("keyword not folded");
endmodule // acp_parser_assertions
bind acp_parser acp_parser_assertions #(.VW(VW)) chk_u (.*);
`default_nettype wire

/* acp_host_model.sv */
// Bus controller model: offers bytes and end indications
`timescale 1ns/1ps
`default_nettype none
module acp_host_model (
    input  wire logic       clk,
    input  wire logic       rdy,
    output var  logic       vld,
    output var  logic [7:0] dat,
    output var  logic       end_of_string_indication,
    output var  logic       end_of_text_indication
);
    initial {vld, dat, end_of_string_indication, end_of_text_indication} = 11'h3fc;
    // Hold each item until a rising edge sees ready
    task put(input logic [7:0] b, input logic s, input logic t);
        @(negedge clk);
        {vld, dat, end_of_string_indication, end_of_text_indication} = {1'b1, b, s, t};
        @(posedge clk);
        repeat (200) if (rdy !== 1'b1) @(posedge clk);
    endtask
    // Typed text: ASCII digits, spaces, decimal negatives
    // 01 ends a string, 02 a text; a tilde doubles the next byte
    task send(input string s);
        logic dbl;
        dbl = 0;
        foreach (s[i])
        begin
            if (s[i] == "~")
                dbl = 1;
            else
            begin
                repeat (dbl ? 2 : 1) put(s[i], s[i] == 8'h01, s[i] == 8'h02);
                dbl = 0;
            end
        end
        @(negedge clk);
        {vld, end_of_string_indication, end_of_text_indication} = 3'h0;
        dat = ~dat; // No stale byte
    endtask
endmodule // acp_host_model
`default_nettype wire

/* test_ascii_command_parser.sv */
// Self-checking bench for the ASCII command parser
`timescale 1ns/1ps
`default_nettype none
`include "acp_regs.vh"
module test_ascii_command_parser;
    localparam logic [3:0] KH = `ACP_TK_HDR, KR = `ACP_TK_ROOT, KN = `ACP_TK_NUM, KU = `ACP_TK_UNIT;
    localparam logic [3:0] KS = `ACP_TK_STR, KK = `ACP_TK_KEY, KP = `ACP_TK_PSEP, KC = `ACP_TK_CMDEND;
    localparam logic [3:0] KX = `ACP_TK_EXEC, KE = `ACP_TK_ERR, KM = `ACP_TK_COMMON, KB = `ACP_TK_BLOCK;
    logic        clk = 0, srst = 1, ifc = 0, pint = 0, pend = 0, hold = 0, blk = 0;
    logic        tok_ready = 0, lsv = 0, lsval = 0, kwv = 0, tx_ready = 0;
    logic [7:0]  kwd = 8'h00;
    wire         rx_valid, rx_eos, rx_eot, rx_ready, tok_valid, flush, long_form, kw_ready, tx_valid, unread;
    wire  [7:0]  rx_data, tx_data, expo;
    wire  [3:0]  kind;
    wire  [31:0] value;
    int          fails = 0, total_checks = 0, cyc = 0, nflush = 0;
    logic [43:0] got[$], want[$];
    logic [7:0]  txq[$];
    always #10 clk = ~clk;
    acp_host_model host_u (.clk(clk), .rdy(rx_ready), .vld(rx_valid), .dat(rx_data), .end_of_string_indication(rx_eos), .end_of_text_indication(rx_eot));
    acp_parser #(.VW(32)) dut_u (
        .REF_CLK(clk), .SRST(srst), .IFC(ifc), .RX_VALID(rx_valid), .RX_DATA(rx_data), .RX_EOS(rx_eos),
        .RX_EOT(rx_eot), .RX_READY(rx_ready), .PARAM_INT(pint), .BLOCK_OK(blk), .RSP_PENDING(pend),
        .RSP_FLUSH(flush), .ERR_UNREAD(unread), .TOK_VALID(tok_valid), .TOK_READY(tok_ready), .TOK_KIND(kind),
        .TOK_VALUE(value), .TOK_EXP(expo), .LONG_SET_VALID(lsv), .LONG_SET_VAL(lsval), .LONG_FORM(long_form),
        .RSP_KW_VALID(kwv), .RSP_KW_DATA(kwd), .RSP_KW_READY(kw_ready), .TX_VALID(tx_valid), .TX_DATA(tx_data),
        .TX_READY(tx_ready));
    // Collect tokens and replies; stop a hang
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (tok_valid && tok_ready) got.push_back({kind, value, expo});
        if (tx_valid && tx_ready) txq.push_back(tx_data);
        if (flush === 1'b1 && unread === 1'b1) nflush <= nflush + 1;
        if (cyc == 20000)
        begin
            fails++;
            end_of_test();
        end
    end
    // Stalls make the buffers hold words
    always @(negedge clk)
    begin
        tok_ready <= !hold && cyc[1:0] != 2'h0;
        tx_ready <= cyc[1:0] != 2'h2;
    end
    task check(input logic [43:0] seen, input logic [43:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Value only for character and number tokens
    function automatic logic [43:0] msk(input logic [43:0] t);
        logic c;
        c = t[43:40] inside {KH, KU, KS, KK, KN, KB};
        return {t[43:40], c ? t[39:8] : 32'h0, t[43:40] == KN ? t[7:0] : 8'h0};
    endfunction
    task e(input logic [3:0] k, input logic [31:0] v = 0, input logic [7:0] x = 0);
        want.push_back({k, v, x});
    endtask
    task run(input string s);
        host_u.send(s);
        repeat (500) if (got.size() < want.size()) @(posedge clk);
        repeat (4) @(negedge clk);
        check(44'(got.size()), 44'(want.size()));
        foreach (want[i]) if (i < got.size()) check(msk(got[i]), msk(want[i]));
        got = {};
        want = {};
    endtask
    task kw(input string s);
        foreach (s[i])
        begin
            @(negedge clk);
            {kwv, kwd} = {1'b1, s[i]};
            @(posedge clk);
            repeat (50) if (kw_ready !== 1'b1) @(posedge clk);
        end
        @(negedge clk);
        {kwv, kwd} = {1'b0, ~kwd};
    endtask
    task t_walk;
        e(KR); e(KH, "A"); e(KN, 12); e(KP); e(KK, "X"); e(KX);
        run(":A 12~,x\n");
        e(KH, "B"); e(KN, 28); e(KP); e(KN, 28); e(KP); e(KN, 28); e(KX);
        run("B #B11100~ , #Q34~,#H1C~\n");
        $display("walk done");
    endtask
    task t_real;
        e(KH, "C"); e(KN, 28); e(KP); e(KN, 280, 8'hff); e(KP); e(KN, 28000); e(KU, "M"); e(KX);
        run("C 0.28E2~,280e-1~,28000~m\n");
        pint = 1;
        e(KH, "D"); e(KN, 2); e(KX);
        run("D 2.75~\n");
        pint = 0;
        $display("numbers done");
    endtask
    task t_text;
        e(KH, "E"); e(KS, " "); e(KS, "I"); e(KS, "n"); e(KP); e(KS, "B"); e(KS, "a"); e(KX);
        run("E ' In',\"Ba\"\n");
        e(KH, "F"); e(KX); e(KH, "G"); e(KX);
        run("F\001G\002");
        e(KH, "G"); e(KC); e(KR); e(KH, "H"); e(KC); e(KM); e(KH, "K"); e(KX);
        run("G;:H;*K\n");
        e(KM); e(KE); e(KX); e(KH, "M"); e(KE); e(KX);
        run("* K\nM\tx\n");
        blk = 1;
        e(KH, "P"); e(KB, "2"); e(KB, "a"); e(KX);
        run("P #2a\n");
        blk = 0;
        e(KH, "P"); e(KE); e(KX);
        run("P #2\n");
        $display("text done");
    endtask
    task t_clear;
        int k;
        hold = 1;
        host_u.send("AB");
        check(44'(rx_ready), 44'h0);
        ifc = 1;
        @(negedge clk);
        ifc = 0;
        check(44'(tok_valid), 44'h0);
        hold = 0;
        pend = 1;
        k = nflush;
        e(KH, "N"); e(KX);
        run("N\n");
        pend = 0;
        check(44'(nflush - k), 44'h1);
        $display("clear done");
    endtask
    task t_resp;
        logic [31:0] w;
        for (int m = 0; m < 2; m++)
        begin
            {lsv, lsval} = {1'b1, m[0]};
            @(negedge clk);
            lsv = 0;
            check(44'(long_form), 44'(m));
            kw("Long");
            repeat (8) @(negedge clk);
            w = 0;
            foreach (txq[i]) w = {w[23:0], txq[i]};
            check(44'(w), m ? 44'("LONG") : 44'("L"));
            txq = {};
        end
        $display("response done");
    endtask
    task end_of_test;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (16) @(negedge clk);
        srst = 0;
        t_walk;
        t_real;
        t_text;
        t_clear;
        t_resp;
        end_of_test;
    end
endmodule // test_ascii_command_parser
`default_nettype wire
